// *** scd_pkg.sv ***
package scd_pkg;

  // ----------------------------------------------------------------
  // ratio encoding (log2 of the oversampling ratio)
  // ----------------------------------------------------------------
  localparam logic [3:0] SCD_LG_DOUBLE = 4'h6;
  localparam logic [3:0] SCD_LG_BASE = 4'h7;
  localparam logic [3:0] SCD_LG_SINC3_MAX = 4'ha;
  localparam logic [3:0] SCD_LG_ONE = 4'h1;

  // ----------------------------------------------------------------
  // phase offset field and limits
  // ----------------------------------------------------------------
  localparam int unsigned SCD_PHASE_W = 10;
  localparam logic signed [10:0] SCD_PHASE_CAP = 11'sh200;
  localparam logic [10:0] SCD_PHASE_ONE = 11'h001;

  // ----------------------------------------------------------------
  // counters and widths
  // ----------------------------------------------------------------
  localparam int unsigned SCD_POS_W = 14;
  localparam int unsigned SCD_ONES_W = 15;
  localparam int unsigned SCD_SINC3_W = 31;
  localparam logic [SCD_POS_W-1:0] SCD_POS_RST = 14'h0000;
  localparam logic [1:0] SCD_STARTUP_CONV = 2'h2;
  localparam logic [1:0] SCD_CONV_RST = 2'h0;

  // ----------------------------------------------------------------
  // settling interval, in modulator clock periods
  // ----------------------------------------------------------------
  localparam logic [15:0] SCD_SETTLE_MULT = 16'h0003;
  localparam logic [15:0] SCD_SETTLE_FIXED = 16'h002c;
  localparam logic [15:0] SCD_SETTLE_TAIL = 16'h0004;
  localparam logic [15:0] SCD_SETTLE_TWO = 16'h0002;
  localparam logic [15:0] SCD_SETTLE_ONE = 16'h0001;
  localparam logic [15:0] SCD_SETTLE_RST = 16'h0000;

  // ----------------------------------------------------------------
  // output path selection
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SCD_FAST = 2'b01,
    SCD_SINC3 = 2'b10
  } scd_path_type;

endpackage

// *** scd_win_if.sv ***
`timescale 1ns/10ps
interface scd_win_if;
  logic tick;
  logic restart;
  logic multi;
  logic [3:0] lg;
  logic [3:0] lg3;
  logic dump3;
  logic dump_all;

  modport win (input tick, input lg, input lg3, output dump3, output dump_all);
  modport chan (input tick, input restart, input multi, input lg3, input dump3,
                input dump_all);
endinterface

// *** scd_phase_win.sv ***
`timescale 1ns/10ps
module scd_phase_win (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // window control
  input wire logic [scd_pkg::SCD_PHASE_W-1:0] phase_in,
  input wire logic [scd_pkg::SCD_POS_W-1:0] ref_in,
  scd_win_if.win w
);
  import scd_pkg::*;

  logic signed [10:0] clip_reg;
  logic signed [10:0] clip_next;
  logic signed [10:0] half;
  logic signed [10:0] ph;
  logic [SCD_POS_W-1:0] mask;
  logic [SCD_POS_W-1:0] mask3;
  logic [SCD_POS_W-1:0] pos;

  // ----------------------------------------------------------------
  // clipping of the programmed offset
  // ----------------------------------------------------------------
  always_comb begin
    ph = signed'({phase_in[SCD_PHASE_W-1], phase_in});
    if (w.lg >= SCD_LG_SINC3_MAX) begin
      half = SCD_PHASE_CAP;
    end else begin
      half = signed'(SCD_PHASE_ONE << (w.lg - SCD_LG_ONE));
    end
    if (ph > half - 11'sh001) begin
      clip_next = half - 11'sh001;
    end else if (ph < -half) begin
      clip_next = -half;
    end else begin
      clip_next = ph;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      clip_reg <= 11'sh000;
    end else begin
      clip_reg <= clip_next;
    end
  end

  // ----------------------------------------------------------------
  // window position: shared count shifted by this channel's offset
  // ----------------------------------------------------------------
  always_comb begin
    mask = SCD_POS_W'((15'h0001 << w.lg) - 15'h0001);
    mask3 = SCD_POS_W'((15'h0001 << w.lg3) - 15'h0001);
    pos = (ref_in - {{3{clip_reg[10]}}, clip_reg}) & mask;
  end

  assign w.dump3 = w.tick && ((pos & mask3) == mask3);
  assign w.dump_all = w.tick && (pos == mask);
endmodule

// *** scd_sinc_chan.sv ***
`timescale 1ns/10ps
module scd_sinc_chan #(
  parameter int unsigned DW = 36
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // modulator bit and window
  input wire logic bit_in,
  scd_win_if.chan w,
  // results
  output logic [DW-1:0] sinc_out,
  output logic [DW-1:0] fast_out,
  output logic done_out
);
  import scd_pkg::*;

  logic [SCD_SINC3_W-1:0] i1_reg, i2_reg, i3_reg, d1_reg, d2_reg, d3_reg;
  logic [SCD_SINC3_W-1:0] i1_next, i2_next, i3_next, d1_next, d2_next, d3_next;
  logic [SCD_SINC3_W-1:0] c1, c2, c3;
  logic [DW-1:0] acc_reg, acc_next, sinc_reg, sinc_next, fast_reg, fast_next;
  logic [SCD_ONES_W-1:0] ones_reg, ones_next, ones_plus;
  logic done_reg, done_next;

  // ----------------------------------------------------------------
  // sinc3 integrate/comb, sinc1 sum, first-order fast path
  // ----------------------------------------------------------------
  always_comb begin
    c1 = i3_reg - d1_reg;
    c2 = c1 - d2_reg;
    c3 = c2 - d3_reg;
    ones_plus = ones_reg + SCD_ONES_W'(bit_in);
    {i1_next, i2_next, i3_next} = {i1_reg, i2_reg, i3_reg};
    {d1_next, d2_next, d3_next} = {d1_reg, d2_reg, d3_reg};
    acc_next = acc_reg;
    sinc_next = sinc_reg;
    fast_next = fast_reg;
    ones_next = ones_reg;
    done_next = 1'b0;
    if (w.restart) begin
      // a restarted filter starts empty and must settle again
      {i1_next, i2_next, i3_next} = '0;
      {d1_next, d2_next, d3_next} = '0;
      acc_next = '0;
      ones_next = '0;
    end else if (w.tick) begin
      i1_next = i1_reg + SCD_SINC3_W'(bit_in);
      i2_next = i2_reg + i1_reg;
      i3_next = i3_reg + i2_reg;
      ones_next = ones_plus;
      if (w.dump3) begin
        d1_next = i3_reg;
        d2_next = c1;
        d3_next = c2;
        acc_next = acc_reg + DW'(c3);
      end
      if (w.dump_all) begin
        sinc_next = w.multi ? acc_reg + DW'(c3) : DW'(c3);
        acc_next = '0;
        // scaled so both paths share the sinc3 gain
        fast_next = DW'(ones_plus) << {w.lg3, 1'b0};
        ones_next = '0;
        done_next = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      {i1_reg, i2_reg, i3_reg, d1_reg, d2_reg, d3_reg} <= '0;
      acc_reg <= '0;
      sinc_reg <= '0;
      fast_reg <= '0;
      ones_reg <= '0;
      done_reg <= 1'b0;
    end else begin
      {i1_reg, i2_reg, i3_reg} <= {i1_next, i2_next, i3_next};
      {d1_reg, d2_reg, d3_reg} <= {d1_next, d2_next, d3_next};
      acc_reg <= acc_next;
      sinc_reg <= sinc_next;
      fast_reg <= fast_next;
      ones_reg <= ones_next;
      done_reg <= done_next;
    end
  end

  assign sinc_out = sinc_reg;
  assign fast_out = fast_reg;
  assign done_out = done_reg;
endmodule

// *** scd_decimator.sv ***
`timescale 1ns/10ps
// What this block does
// - each channel switches to the sinc3 path after two conversions from reset.
// - ratios 64 to 1024 use the sinc3 output directly at full ratio.
// - ratios 2048 and up run sinc3 at 1024, then sinc1 by 2 to 16.
// - nulls at multiples of output rate, repeating at modulator rate multiples.
// - enable, mux or gain change, or resync restarts the filter to settle.
// - results keep coming while settling, never held back nor marked.
// - settling is 3*ratio+44+4, or (2*k+2)*1024+48 above 1024.
// - up to 1024 the response is the cubed sinc of length ratio.
// - each channel's phase offset is a 10-bit signed modulator cycle count.
// - each result covers one ratio of consecutive modulator samples, except the first after a restart.
// - equal offsets make all channels' windows line up in time.
// - a channel's window moves by its clipped offset against the others.
// - first two results come from a first-order fast path, then sinc3.
// - three-bit field picks 128 to 16384; double-rate picks 64.
// - offset clips to -ratio/2 .. ratio/2-1, and to -512..511 above 1024.
module scd_decimator #(
  parameter int unsigned NCH = 3,
  parameter int unsigned DW = 36
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // modulator stream, one bit per channel on each tick
  input wire logic mod_tick_in,
  input wire logic [NCH-1:0] mod_bits_in,
  // configuration
  input wire logic [2:0] osr_sel_in,
  input wire logic double_rate_in,
  input wire logic standby_in,
  input wire logic resync_in,
  input wire logic [NCH-1:0] ch_enable_in,
  input wire logic [NCH-1:0] ch_setting_change_in,
  input wire logic [NCH*scd_pkg::SCD_PHASE_W-1:0] channel_phase_offset_in,
  // results
  output logic [NCH*DW-1:0] data_out,
  output logic [NCH-1:0] data_valid_out,
  output logic [NCH-1:0] sinc3_path_out,
  // status
  output logic [15:0] settle_time_out
);
  import scd_pkg::*;

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_meta_reg;
  logic rst_n_reg;

  // the release passes two flops so no flop leaves reset on a different edge
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg <= rst_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // ratio decode
  // ----------------------------------------------------------------
  logic [3:0] lg_reg;
  logic [3:0] lg_next;
  logic [3:0] lg3;
  logic multi;
  logic ratio_changed;

  always_comb begin
    if (double_rate_in) begin
      lg_next = SCD_LG_DOUBLE;
    end else begin
      lg_next = SCD_LG_BASE + {1'b0, osr_sel_in};
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      lg_reg <= SCD_LG_BASE;
    end else begin
      lg_reg <= lg_next;
    end
  end

  always_comb begin
    multi = lg_reg > SCD_LG_SINC3_MAX;
    lg3 = multi ? SCD_LG_SINC3_MAX : lg_reg;
    // a ratio change mid-conversion is the host's mistake; restart cleanly
    ratio_changed = lg_next != lg_reg;
  end

  // ----------------------------------------------------------------
  // shared modulator position count
  // ----------------------------------------------------------------
  logic [SCD_POS_W-1:0] ref_reg;
  logic [SCD_POS_W-1:0] ref_next;
  logic [SCD_POS_W-1:0] ref_mask;
  logic global_restart;

  always_comb begin
    global_restart = standby_in || resync_in || ratio_changed;
    ref_mask = SCD_POS_W'((15'h0001 << lg_reg) - 15'h0001);
    ref_next = ref_reg;
    if (global_restart) begin
      ref_next = SCD_POS_RST;
    end else if (mod_tick_in) begin
      // one count for all channels keeps equal offsets aligned
      ref_next = (ref_reg + 14'h0001) & ref_mask;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      ref_reg <= SCD_POS_RST;
    end else begin
      ref_reg <= ref_next;
    end
  end

  // ----------------------------------------------------------------
  // settling interval for the current ratio
  // ----------------------------------------------------------------
  logic [15:0] settle_reg;
  logic [15:0] settle_next;
  logic [15:0] ratio16;
  logic [15:0] sinc1_k;

  always_comb begin
    ratio16 = SCD_SETTLE_ONE << lg_reg;
    sinc1_k = ratio16 >> SCD_LG_SINC3_MAX;
    if (!multi) begin
      settle_next = 16'(SCD_SETTLE_MULT * ratio16) + SCD_SETTLE_FIXED
                    + SCD_SETTLE_TAIL;
    end else begin
      settle_next = (((sinc1_k << 1) + SCD_SETTLE_TWO) << SCD_LG_SINC3_MAX)
                    + SCD_SETTLE_FIXED + SCD_SETTLE_TAIL;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      settle_reg <= SCD_SETTLE_RST;
    end else begin
      settle_reg <= settle_next;
    end
  end

  assign settle_time_out = settle_reg;

  // ----------------------------------------------------------------
  // per-channel filters and output selection
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : gen_ch
      scd_win_if win ();
      logic [DW-1:0] sinc_val;
      logic [DW-1:0] fast_val;
      logic done;
      scd_path_type path_reg;
      scd_path_type path_next;
      logic [1:0] conv_reg;
      logic [1:0] conv_next;
      logic [DW-1:0] data_reg;
      logic [DW-1:0] data_next;
      logic valid_reg;
      logic valid_next;

      assign win.tick = mod_tick_in;
      assign win.lg = lg_reg;
      assign win.lg3 = lg3;
      assign win.multi = multi;
      // the filter notches follow the modulator rate because the
      // window is counted in modulator ticks, not main clocks
      assign win.restart = global_restart || !ch_enable_in[g]
                           || ch_setting_change_in[g];

      scd_phase_win u_win (
        .clk_in(clk_in),
        .rst_n_in(rst_n_reg),
        .phase_in(channel_phase_offset_in[g*SCD_PHASE_W +: SCD_PHASE_W]),
        .ref_in(ref_reg),
        .w(win.win)
      );

      scd_sinc_chan #(
        .DW(DW)
      ) u_chan (
        .clk_in(clk_in),
        .rst_n_in(rst_n_reg),
        .bit_in(mod_bits_in[g]),
        .w(win.chan),
        .sinc_out(sinc_val),
        .fast_out(fast_val),
        .done_out(done)
      );

      // only reset returns to the fast path; resync and standby do not
      always_comb begin
        path_next = path_reg;
        conv_next = conv_reg;
        data_next = data_reg;
        valid_next = 1'b0;
        if (done) begin
          valid_next = 1'b1;
          unique case (path_reg)
            SCD_FAST: begin
              data_next = fast_val;
              conv_next = conv_reg + 2'h1;
              if (conv_reg + 2'h1 == SCD_STARTUP_CONV) begin
                path_next = SCD_SINC3;
              end
            end
            SCD_SINC3: begin
              data_next = sinc_val;
            end
            default: begin
              path_next = SCD_FAST;
            end
          endcase
        end
      end

      always_ff @(posedge clk_in or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
          path_reg <= SCD_FAST;
          conv_reg <= SCD_CONV_RST;
          data_reg <= '0;
          valid_reg <= 1'b0;
        end else begin
          path_reg <= path_next;
          conv_reg <= conv_next;
          data_reg <= data_next;
          valid_reg <= valid_next;
        end
      end

      assign data_out[g*DW +: DW] = data_reg;
      assign data_valid_out[g] = valid_reg;
      assign sinc3_path_out[g] = path_reg == SCD_SINC3;
    end
  endgenerate
endmodule

// *** scd_mod_model.sv ***
`timescale 1ns/10ps
// ----------------------------------------------------------------
// modulator bitstream source, one bit per channel on each tick
// ----------------------------------------------------------------
module scd_mod_model #(
  parameter int unsigned NCH = 3
) (
  // clock
  input wire logic clk_in,
  // control
  input wire logic run_in,
  input wire logic slow_in,
  input wire logic [NCH-1:0] alt_in,
  input wire logic [NCH-1:0] level_in,
  // stream
  output logic tick_out,
  output logic [NCH-1:0] bits_out
);
  logic [NCH-1:0] cur_reg;
  logic ph_reg;
  logic go_reg;
  initial begin
    tick_out = 1'b0;
    bits_out = '0;
    cur_reg = '0;
    ph_reg = 1'b0;
    go_reg = 1'b0;
  end
  always @(posedge clk_in) begin
    // controls are read at the edge, before the bench moves them
    ph_reg = slow_in ? !ph_reg : 1'b1;
    go_reg = run_in && ph_reg;
    #1;
    // samples keep coming at the modulator rate while running
    if (go_reg) begin
      cur_reg = (alt_in & ~cur_reg) | (~alt_in & level_in);
      tick_out = 1'b1;
      bits_out = cur_reg;
    end else begin
      // off-tick bits are not sampled, so show the inverse to catch a wrong sample
      tick_out = 1'b0;
      bits_out = ~cur_reg;
    end
  end
endmodule

// *** scd_decimator_sva.sv ***
`timescale 1ns/10ps
module scd_decimator_sva #(
  parameter int unsigned NCH = 3,
  parameter int unsigned DW = 36
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // stream and configuration
  input wire logic mod_tick_in,
  input wire logic [NCH-1:0] mod_bits_in,
  input wire logic [2:0] osr_sel_in,
  input wire logic double_rate_in,
  input wire logic standby_in,
  input wire logic resync_in,
  input wire logic [NCH-1:0] ch_enable_in,
  input wire logic [NCH-1:0] ch_setting_change_in,
  input wire logic [NCH*scd_pkg::SCD_PHASE_W-1:0] channel_phase_offset_in,
  // results
  input wire logic [NCH*DW-1:0] data_out,
  input wire logic [NCH-1:0] data_valid_out,
  input wire logic [NCH-1:0] sinc3_path_out,
  input wire logic [15:0] settle_time_out
);
  import scd_pkg::*;
  logic [3:0] live_reg;
  logic [3:0] live_next;
  logic [1:0] nval_reg;
  logic [1:0] nval_next;
  always_comb begin
    live_next = live_reg;
    nval_next = nval_reg;
    if (live_reg != 4'h8) begin
      live_next = live_reg + 4'h1;
    end
    if (data_valid_out[0] && nval_reg != 2'h2) begin
      nval_next = nval_reg + 2'h1;
    end
  end
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      live_reg <= 4'h0;
      nval_reg <= 2'h0;
    end else begin
      live_reg <= live_next;
      nval_reg <= nval_next;
    end
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  a_valid_spacing: assert property (
    data_valid_out[0] |=> !data_valid_out[0] [*8]) else $error("result pulses too close");
  a_valid_after_tick: assert property (
    |data_valid_out |-> $past(mod_tick_in, 2)) else $error("result without closing tick");
  a_data_holds: assert property (
    live_reg == 4'h8 && !(|data_valid_out) |-> $stable(data_out))
    else $error("data moved without a result pulse");
  a_path_never_falls: assert property (
    ($past(sinc3_path_out) & ~sinc3_path_out) == '0) else $error("path fell back");
  a_path_rise_valid: assert property (
    ((sinc3_path_out & ~$past(sinc3_path_out)) & ~data_valid_out) == '0)
    else $error("path changed off a result");
  a_path_after_two: assert property (
    data_valid_out[0] |-> sinc3_path_out[0] == (nval_reg != 2'h0))
    else $error("path switch at wrong result");
  a_settle_double: assert property (
    (live_reg == 4'h8 && double_rate_in) [*4] |-> settle_time_out == 16'h00f0)
    else $error("settle time wrong at ratio 64");
  a_settle_ratio_2048: assert property (
    (live_reg == 4'h8 && !double_rate_in && osr_sel_in == 3'h4) [*4]
    |-> settle_time_out == 16'h1830) else $error("settle time wrong at ratio 2048");
  a_restart_quiet: assert property (
    $past(standby_in, 2) || $past(resync_in, 2) |-> data_valid_out == '0)
    else $error("result from a refused tick");
  a_disabled_quiet: assert property (
    ($past(~ch_enable_in, 2) & data_valid_out) == '0)
    else $error("result from a disabled channel");
endmodule
bind scd_decimator scd_decimator_sva #(.NCH(NCH), .DW(DW)) i_sva (
  .clk_in(clk_in), .rstn_in(rstn_in), .mod_tick_in(mod_tick_in), .mod_bits_in(mod_bits_in),
  .osr_sel_in(osr_sel_in), .double_rate_in(double_rate_in), .standby_in(standby_in),
  .resync_in(resync_in), .ch_enable_in(ch_enable_in),
  .ch_setting_change_in(ch_setting_change_in),
  .channel_phase_offset_in(channel_phase_offset_in), .data_out(data_out),
  .data_valid_out(data_valid_out), .sinc3_path_out(sinc3_path_out),
  .settle_time_out(settle_time_out));

// *** scd_decimator_tb_top.sv ***
`timescale 1ns/10ps
module scd_decimator_tb_top;
  import scd_pkg::*;
  localparam int unsigned NCH = 3;
  localparam int unsigned DW = 36;
  logic clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic mod_tick;
  logic [NCH-1:0] mod_bits;
  logic [2:0] osr_sel = 3'h0;
  logic double_rate = 1'b0;
  logic standby = 1'b1;
  logic resync = 1'b0;
  logic [NCH-1:0] ch_enable = 3'h7;
  logic [NCH-1:0] ch_change = 3'h0;
  logic [NCH*SCD_PHASE_W-1:0] phase = 30'h0000_0000;
  logic run = 1'b0;
  logic slow = 1'b0;
  logic [NCH*DW-1:0] data;
  logic [NCH-1:0] valid;
  logic [NCH-1:0] path;
  logic [15:0] settle;
  int err_total = 0;
  int n_checks = 0;
  int cyc = 0;
  int t0;
  int tf [NCH];
  always #2.5 clk_in = ~clk_in;
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  always @(posedge clk_in) begin
    cyc = cyc + 1;
    if (cyc == 60000) begin
      err_total++;
      $display("BAD timeout expected finish seen hang");
      complete_run();
    end
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic cmp(input string name, input logic [63:0] exp, input logic [63:0] got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %0h seen %0h", name, exp, got);
    end
  endtask
  task automatic wait_valid(input int g);
    int k;
    k = 0;
    do begin
      step(1);
      k++;
    end while (valid[g] !== 1'b1 && k < 5000);
    cmp("valid_seen", 1, valid[g]);
  endtask
  function automatic logic [DW-1:0] dch(input int g);
    return data[g*DW +: DW];
  endfunction
  function automatic logic [63:0] settle_exp(input int r);
    return (r <= 1024) ? 64'(3 * r + 48) : 64'((2 * (r / 1024) + 2) * 1024 + 48);
  endfunction
  // ch0 all ones, ch1 all zeros, ch2 alternating
  scd_mod_model #(.NCH(NCH)) i_mod (.clk_in(clk_in), .run_in(run), .slow_in(slow),
    .alt_in(3'h4), .level_in(3'h1), .tick_out(mod_tick), .bits_out(mod_bits));
  scd_decimator #(.NCH(NCH), .DW(DW)) i_dut (.clk_in(clk_in), .rstn_in(rstn_in),
    .mod_tick_in(mod_tick), .mod_bits_in(mod_bits), .osr_sel_in(osr_sel),
    .double_rate_in(double_rate), .standby_in(standby), .resync_in(resync),
    .ch_enable_in(ch_enable), .ch_setting_change_in(ch_change),
    .channel_phase_offset_in(phase), .data_out(data), .data_valid_out(valid),
    .sinc3_path_out(path), .settle_time_out(settle));
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    step(6);
    rstn_in = 1'b1;
    step(4);
    cmp("path_reset", 0, path);
    // ratio is only changed while in standby
    for (int s = 0; s < 8; s++) begin
      osr_sel = 3'(s);
      step(4);
      cmp("settle", settle_exp(128 << s), settle);
    end
    double_rate = 1'b1;
    step(4);
    cmp("settle_64", settle_exp(64), settle);
    $display("test settle done");
    standby = 1'b0;
    run = 1'b1;
    wait_valid(0);
    cmp("aligned", 7, valid);
    cmp("fast_path", 0, path);
    cmp("fast_ones", 36'h0_0004_0000, dch(0));
    cmp("fast_alt", 36'h0_0002_0000, dch(2));
    t0 = cyc;
    wait_valid(0);
    cmp("window_len", 64, cyc - t0);
    cmp("sinc3_path", 7, path);
    // early results are unsettled and only read after settling plus one period
    repeat (4) wait_valid(0);
    cmp("sinc3_ones", 36'h0_0004_0000, dch(0));
    cmp("sinc3_zero", 0, dch(1));
    cmp("sinc3_alt", 36'h0_0002_0000, dch(2));
    slow = 1'b1;
    wait_valid(0);
    t0 = cyc;
    wait_valid(0);
    cmp("window_slow", 128, cyc - t0);
    slow = 1'b0;
    $display("test ratio 64 done");
    step(20);
    ch_change = 3'h1;
    step(1);
    ch_change = 3'h0;
    wait_valid(0);
    cmp("restart_partial", 1, dch(0) < 36'h0_0004_0000);
    cmp("path_kept", 7, path);
    cmp("other_chan", 36'h0_0002_0000, dch(2));
    ch_enable = 3'h6;
    tf = '{default: 0};
    repeat (64) begin
      step(1);
      for (int g = 0; g < NCH; g++) begin
        if (valid[g] === 1'b1) begin
          tf[g]++;
        end
      end
    end
    cmp("disabled_quiet", 0, tf[0]);
    cmp("enabled_runs", 1, tf[2]);
    ch_enable = 3'h7;
    wait_valid(0);
    cmp("enable_partial", 1, dch(0) < 36'h0_0004_0000);
    $display("test restart done");
    phase = {10'h3d8, 10'h064, 10'h000};
    step(2);
    resync = 1'b1;
    step(1);
    resync = 1'b0;
    tf = '{default: 0};
    repeat (200) begin
      step(1);
      for (int g = 0; g < NCH; g++) begin
        if (valid[g] === 1'b1 && tf[g] == 0) begin
          tf[g] = cyc;
        end
      end
    end
    cmp("phase_hi", 31, (tf[1] - tf[0]) & 63);
    cmp("phase_lo", 32, (tf[2] - tf[0]) & 63);
    $display("test phase done");
    standby = 1'b1;
    double_rate = 1'b0;
    osr_sel = 3'h4;
    phase = 30'h0000_0000;
    step(4);
    standby = 1'b0;
    wait_valid(0);
    t0 = cyc;
    wait_valid(0);
    cmp("window_2048", 2048, cyc - t0);
    repeat (3) wait_valid(0);
    cmp("sinc1_ones", 36'h0_8000_0000, dch(0));
    cmp("sinc1_alt", 36'h0_4000_0000, dch(2));
    $display("test ratio 2048 done");
    complete_run();
  end
endmodule
